// ---- core/idb_defines.svh ----
// Constants of the identification word bank: addresses, field layouts, fixed values.
// Assumes inclusion by bare name from the package, the design modules and the bench.
`ifndef IDB_DEFINES_SVH
`define IDB_DEFINES_SVH

// Word addresses in the extended special register space.
`define IDB_ADDR_PROG        16'hF078
`define IDB_ADDR_MEMORY      16'hF07A
`define IDB_ADDR_PART        16'hF07C
`define IDB_ADDR_MAKER       16'hF07E

// Maker word: code above a fixed low pattern.
`define IDB_MAKER_LOW        5'h03
`define IDB_MAKER_LOW_W      5

// Part word: revision in the lowest nibble.
`define IDB_REV_W            4

// Memory word: kind in bits 15..12, capacity code in bits 11..0.
`define IDB_KIND_W           4
`define IDB_SIZE_W           12
`define IDB_KIND_NONE        4'h0
`define IDB_KIND_MASK_ROM    4'h1
`define IDB_KIND_STD_FLASH   4'h2
`define IDB_KIND_HP_FLASH    4'h3
`define IDB_SIZE_DEFAULT     12'h0D0
`define IDB_MEM_BUSY_MASK    16'hC000
`define IDB_MEM_BUSY_HI      15
`define IDB_MEM_BUSY_LO      14

// Programming voltage word.
`define IDB_PROG_VPP_NONE    8'h00
`define IDB_PROG_VDD_5V      8'h40

// Field positions inside the words, for checks that look at one field at a time.
`define IDB_REV_HI           3
`define IDB_REV_LO           0
`define IDB_SIZE_HI          11
`define IDB_SIZE_LO          0
`define IDB_KIND_HI          15
`define IDB_KIND_LO          12
`define IDB_VDD_HI           7
`define IDB_VDD_LO           0
`define IDB_VPP_HI           15
`define IDB_VPP_LO           8

// Settle count before the strap is taken.
`define IDB_SETTLE_CNT       2'h2

// Expected word values.
`define IDB_MEM_READY_WORD   16'h30D0
`define IDB_MEM_BUSY_WORD    16'hF0D0
`define IDB_PROG_WORD        16'h0040
`define IDB_ZERO_WORD        16'h0000

`endif

// ---- core/idb_pkg.sv ----
// Types shared by the identification word bank and its flash-init tracker.
// Assumes idb_defines.svh is on the include path.
`include "idb_defines.svh"

package idb_pkg;

    // Progress of the flash initialisation seen from the bank.
    typedef enum logic [1:0] {
        IDB_SETTLE,
        IDB_BUSY,
        IDB_READY
    } idb_fsm_type;

    // All state of the tracker.
    typedef struct packed {
        logic        ea_s1;
        logic        ea_s2;
        logic        done_s1;
        logic        done_s2;
        logic [1:0]  settle;
        idb_fsm_type fsm;
        logic        strap_internal;
    } idb_track_state_type;

    // All state of the bank read port.
    typedef struct packed {
        logic [15:0] rdata;
        logic        rd_valid;
        logic        hit;
        logic        wr_ignored;
    } idb_bank_state_type;

endpackage

// ---- core/idb_init_if.sv ----
// Carries the flash-init status from the tracker to the bank.
// Assumes both ends run on the system clock.
interface idb_init_if;
    logic ready;
    logic strap_internal;

    modport tracker (output ready, output strap_internal);
    modport bank    (input ready, input strap_internal);
endinterface

// ---- core/idb_init_track.sv ----
// Flash-init tracker: synchronises the strap pin and the flash done level.
// Assumes the flash controller raises its done level once and holds it until reset.
`include "idb_defines.svh"

module idb_init_track (
    input  wire logic clk,
    input  wire logic rst_b,
    input  wire logic ext_access_pin,
    input  wire logic flash_done,
    idb_init_if.tracker init
);

    idb_pkg::idb_track_state_type s_q;
    idb_pkg::idb_track_state_type s_d;

    ////////////////////////////////////////////////////////////////////////////////
    // Next state. The strap is taken only after the synchroniser has filled, so a
    // pin level never reaches a flop through the asynchronous reset.
    always_comb
    begin
        s_d         = s_q;
        s_d.ea_s1   = ext_access_pin;
        s_d.ea_s2   = s_q.ea_s1;
        s_d.done_s1 = flash_done;
        s_d.done_s2 = s_q.done_s1;
        unique case (s_q.fsm)
            idb_pkg::IDB_SETTLE:
            begin
                if (s_q.settle == `IDB_SETTLE_CNT)
                begin
                    s_d.strap_internal = s_q.ea_s2;
                    // Internal start: flash already initialised, words valid at once.
                    if (s_q.ea_s2 || s_q.done_s2)
                        s_d.fsm = idb_pkg::IDB_READY;
                    else
                        s_d.fsm = idb_pkg::IDB_BUSY;
                end
                else
                    s_d.settle = s_q.settle + 2'h1;
            end
            idb_pkg::IDB_BUSY:
            begin
                // External start: wait for the flash to finish.
                if (s_q.done_s2)
                    s_d.fsm = idb_pkg::IDB_READY;
            end
            idb_pkg::IDB_READY:
            begin
                s_d.fsm = idb_pkg::IDB_READY;
            end
        endcase
    end

    // State register with constant reset values.
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            s_q <= '{ea_s1: 1'b0, ea_s2: 1'b0, done_s1: 1'b0, done_s2: 1'b0,
                     settle: 2'h0, fsm: idb_pkg::IDB_SETTLE, strap_internal: 1'b0};
        else
            s_q <= s_d;
    end

    assign init.ready          = (s_q.fsm == idb_pkg::IDB_READY);
    assign init.strap_internal = s_q.strap_internal;

endmodule

// ---- core/idb_bank.sv ----
// Identification word bank: four read-only 16-bit words in the extended
// special register space, read by the CPU one word at a time.
// Assumes a single-cycle read or write strobe with a word address from the CPU.
`include "idb_defines.svh"

module idb_bank #(
    parameter logic [10:0] MAKER_CODE = 11'h155, // Arbitrary value.
    parameter logic [11:0] PART_CODE  = 12'h5A5, // Arbitrary value.
    parameter logic [3:0]  REVISION   = 4'h1,    // Arbitrary value.
    parameter logic [3:0]  MEM_KIND   = `IDB_KIND_HP_FLASH,
    parameter logic [11:0] MEM_SIZE   = `IDB_SIZE_DEFAULT
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RST_B,
    input  wire logic [15:0] ADDR,
    input  wire logic        RD_STB,
    input  wire logic        WR_STB,
    input  wire logic [15:0] WDATA,
    input  wire logic [1:0]  BYTE_EN,
    input  wire logic        EXT_ACCESS_PIN,
    input  wire logic        FLASH_INIT_DONE,
    output logic      [15:0] RDATA,
    output logic             RD_VALID,
    output logic             HIT,
    output logic             WR_IGNORED,
    output logic             INIT_READY,
    output logic             STRAP_INTERNAL
);

    ////////////////////////////////////////////////////////////////////////////////
    // Elaboration checks: reserved kinds and an empty memory with a size are refused.
    if (MEM_KIND > `IDB_KIND_HP_FLASH)
        $error("Memory kind code is reserved.");
    if ((MEM_KIND == `IDB_KIND_NONE) && (MEM_SIZE != 12'h000))
        $error("A part without internal memory must report size zero.");

    ////////////////////////////////////////////////////////////////////////////////
    // Flash-init tracking lives in its own module; the bank only sees a level.
    idb_init_if init_link ();

    idb_init_track u_track (
        .clk            (CLK_SYS),
        .rst_b          (RST_B),
        .ext_access_pin (EXT_ACCESS_PIN),
        .flash_done     (FLASH_INIT_DONE),
        .init           (init_link.tracker)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Word contents. These are wires, not storage, so no write path can reach them.
    logic [15:0] maker_id_word;
    logic [15:0] part_id_word;
    logic [15:0] memory_id_word;
    logic [15:0] prog_voltage_id_word;
    logic [15:0] memory_ready_word;

    // Maker code sits above the fixed low pattern.
    assign maker_id_word = {MAKER_CODE, `IDB_MAKER_LOW};
    // Device code above, revision follows the silicon in the lowest nibble.
    assign part_id_word = {PART_CODE, REVISION};
    // Kind in the top nibble, capacity code below it, capacity = 4 x code Kbyte.
    assign memory_ready_word = {MEM_KIND, MEM_SIZE};
    // Until the flash is done the top two bits are forced high as a busy flag.
    // Software booting externally polls them; the maker and part words stay valid.
    assign memory_id_word = init_link.ready ? memory_ready_word
                          : (memory_ready_word | `IDB_MEM_BUSY_MASK);
    // No external program supply, five-volt programming code; same before and after.
    assign prog_voltage_id_word = {`IDB_PROG_VPP_NONE, `IDB_PROG_VDD_5V};

    ////////////////////////////////////////////////////////////////////////////////
    // Address decode. Only the four even word addresses match; an odd address misses,
    // so an odd-address byte access never reaches a word; BYTE_EN is not decoded.
    logic        sel_hit;
    logic [15:0] sel_word;

    always_comb
    begin
        sel_hit  = 1'b1;
        sel_word = `IDB_ZERO_WORD;
        unique case (ADDR)
            `IDB_ADDR_MAKER:  sel_word = maker_id_word;
            `IDB_ADDR_PART:   sel_word = part_id_word;
            `IDB_ADDR_MEMORY: sel_word = memory_id_word;
            `IDB_ADDR_PROG:   sel_word = prog_voltage_id_word;
            default:          sel_hit  = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Read port state. A read takes the whole word regardless of byte enables;
    // an unmapped read answers with zero and HIT low so software sees a defined value.
    idb_pkg::idb_bank_state_type s_q;
    idb_pkg::idb_bank_state_type s_d;

    always_comb
    begin
        s_d            = s_q;
        s_d.rd_valid   = RD_STB;
        s_d.hit        = 1'b0;
        s_d.wr_ignored = WR_STB && !RD_STB && sel_hit;
        if (RD_STB)
        begin
            s_d.hit   = sel_hit;
            s_d.rdata = sel_word;
        end
    end

    // Output register; data is held between reads.
    always_ff @(posedge CLK_SYS or negedge RST_B)
    begin
        if (!RST_B)
            s_q <= '{rdata: `IDB_ZERO_WORD, rd_valid: 1'b0, hit: 1'b0, wr_ignored: 1'b0};
        else
            s_q <= s_d;
    end

    assign RDATA          = s_q.rdata;
    assign RD_VALID       = s_q.rd_valid;
    assign HIT            = s_q.hit;
    assign WR_IGNORED     = s_q.wr_ignored;
    assign INIT_READY     = init_link.ready;
    assign STRAP_INTERNAL = init_link.strap_internal;

    ////////////////////////////////////////////////////////////////////////////////
    // Checks on the read port and the init status.
    sequence s_read_at(logic [15:0] a);
        RD_STB && (ADDR == a);
    endsequence

    sequence s_done_held;
        FLASH_INIT_DONE [*4];
    endsequence

    chk_maker_word_value: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MAKER) |=> RD_VALID && HIT
            && (RDATA == {MAKER_CODE, `IDB_MAKER_LOW}))
        else $error("Maker word read returned a wrong value.");

    chk_part_word_value: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PART) |=> HIT && (RDATA[3:0] == REVISION)
            && (RDATA[15:4] == PART_CODE))
        else $error("Part word read returned a wrong value.");

    chk_memory_ready_word: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) ##0 INIT_READY |=> RDATA == `IDB_MEM_READY_WORD)
        else $error("Memory word after init is not the ready value.");

    chk_memory_busy_word: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) ##0 !INIT_READY |=> RDATA == `IDB_MEM_BUSY_WORD)
        else $error("Memory word before init is not the busy value.");

    chk_busy_flag_bits: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) |=> (RDATA[`IDB_MEM_BUSY_HI] == !$past(INIT_READY))
            && (RDATA[`IDB_MEM_BUSY_LO] == !$past(INIT_READY)))
        else $error("Busy flag bits disagree with init status.");

    chk_prog_word_value: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PROG) |=> RDATA == `IDB_PROG_WORD)
        else $error("Programming voltage word read returned a wrong value.");

    chk_write_no_effect: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        WR_STB && !RD_STB |=> $stable(RDATA) && !RD_VALID)
        else $error("A write disturbed the read data.");

    chk_unmapped_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        RD_STB && !(ADDR inside {`IDB_ADDR_MAKER, `IDB_ADDR_PART,
            `IDB_ADDR_MEMORY, `IDB_ADDR_PROG}) |=> !HIT && (RDATA == `IDB_ZERO_WORD))
        else $error("Unmapped read did not answer zero.");

    chk_ready_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        INIT_READY |=> INIT_READY)
        else $error("Init ready fell without a reset.");

    chk_done_to_ready: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_done_held |-> ##[0:2] INIT_READY)
        else $error("Flash done did not raise init ready in time.");

    chk_strap_fast_ready: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        $rose(STRAP_INTERNAL) |-> INIT_READY)
        else $error("Internal start did not make the words ready at once.");

    ////////////////////////////////////////////////////////////////////////////////
    // Handshake and field checks. Fields are checked one by one so that a wrong
    // layout names the field that broke, not only the word.

    // A read of any one of the four mapped words.
    sequence s_read_mapped;
        RD_STB && (ADDR inside {`IDB_ADDR_MAKER, `IDB_ADDR_PART,
            `IDB_ADDR_MEMORY, `IDB_ADDR_PROG});
    endsequence

    // A write alone to a mapped word; a read in the same cycle takes precedence.
    sequence s_write_mapped;
        WR_STB && !RD_STB && (ADDR inside {`IDB_ADDR_MAKER, `IDB_ADDR_PART,
            `IDB_ADDR_MEMORY, `IDB_ADDR_PROG});
    endsequence

    // Every read strobe is answered in the next cycle, with no wait state.
    chk_valid_after_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        RD_STB |=> RD_VALID)
        else $error("A read was not answered in the next cycle.");

    // A valid pulse without a read would let software latch stale data.
    chk_valid_needs_read: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        !RD_STB |=> !RD_VALID)
        else $error("Read valid rose without a read.");

    // Hit qualifies the read data, so it never stands alone.
    chk_hit_needs_valid: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        HIT |-> RD_VALID)
        else $error("Hit seen without read valid.");

    // Each of the four words answers with hit.
    chk_mapped_read_hit: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_mapped |=> RD_VALID && HIT)
        else $error("A mapped word read did not hit.");

    // Data stands between reads; nothing but a read may move it.
    chk_rdata_held: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        !RD_STB |=> $stable(RDATA))
        else $error("Read data moved without a read.");

    // A write to a mapped word is reported as ignored in the next cycle.
    chk_write_flagged: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_write_mapped |=> WR_IGNORED)
        else $error("A write to a word was not flagged as ignored.");

    // The ignored flag is a one-cycle answer to a write, never a level.
    chk_flag_needs_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        !WR_STB |=> !WR_IGNORED)
        else $error("Write ignored rose without a write.");

    // A read in the same cycle as a write wins, so no write is reported then.
    chk_read_beats_write: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        RD_STB |=> !WR_IGNORED)
        else $error("Write ignored raised during a read.");

    // The capacity code is the same before and after init; only the busy bits move.
    chk_capacity_field: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) |=> RDATA[`IDB_SIZE_HI:`IDB_SIZE_LO] == MEM_SIZE)
        else $error("Memory capacity field is wrong.");

    // Once init is done the top nibble carries the memory kind alone.
    chk_kind_field: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) ##0 INIT_READY
            |=> RDATA[`IDB_KIND_HI:`IDB_KIND_LO] == MEM_KIND)
        else $error("Memory kind field is wrong after init.");

    // Reserved kind codes must never reach software once the word is valid.
    chk_kind_not_reserved: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) ##0 INIT_READY
            |=> RDATA[`IDB_KIND_HI:`IDB_KIND_LO] <= `IDB_KIND_HP_FLASH)
        else $error("Memory kind field shows a reserved code.");

    // Software tests the busy bits as a pair, so they must never split.
    chk_busy_bits_pair: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MEMORY) |=> RDATA[`IDB_MEM_BUSY_HI] == RDATA[`IDB_MEM_BUSY_LO])
        else $error("Busy flag bits disagree with each other.");

    // Supply voltage code sits in the low byte of the voltage word.
    chk_voltage_code: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PROG) |=> RDATA[`IDB_VDD_HI:`IDB_VDD_LO] == `IDB_PROG_VDD_5V)
        else $error("Supply voltage code is wrong.");

    // No external program supply: the upper byte stays clear.
    chk_program_supply: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PROG) |=> RDATA[`IDB_VPP_HI:`IDB_VPP_LO] == `IDB_PROG_VPP_NONE)
        else $error("Program supply code is not clear.");

    // The revision nibble follows the silicon in every phase.
    chk_revision_nibble: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PART) |=> RDATA[`IDB_REV_HI:`IDB_REV_LO] == REVISION)
        else $error("Revision nibble is wrong.");

    // The maker word is already final while the flash is busy.
    chk_maker_while_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_MAKER) ##0 !INIT_READY |=> RDATA == {MAKER_CODE, `IDB_MAKER_LOW})
        else $error("Maker word differs while the flash is busy.");

    // The part word is already final while the flash is busy.
    chk_part_while_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PART) ##0 !INIT_READY |=> RDATA == {PART_CODE, REVISION})
        else $error("Part word differs while the flash is busy.");

    // The voltage word shows its fixed value while the flash is busy.
    chk_prog_while_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        s_read_at(`IDB_ADDR_PROG) ##0 !INIT_READY |=> RDATA == `IDB_PROG_WORD)
        else $error("Voltage word differs while the flash is busy.");

    // Ready needs a cause: an internal start, or a done level three edges back.
    chk_ready_has_cause: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        $rose(INIT_READY) |-> STRAP_INTERNAL || $past(FLASH_INIT_DONE, 3))
        else $error("Init ready rose without a cause.");

    // The strap is taken once per reset and then stands.
    chk_strap_sticky: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        STRAP_INTERNAL |=> STRAP_INTERNAL)
        else $error("Captured strap fell without a reset.");

    // An internal start never leaves the words busy.
    chk_strap_not_busy: assert property (@(posedge CLK_SYS) disable iff (!RST_B)
        STRAP_INTERNAL |-> INIT_READY)
        else $error("Internal start seen while the words are busy.");

endmodule

// ---- test/idb_bank_bench.sv ----
// Self-checking bench for the identification word bank: word reads and writes, strap and init.
// Assumes idb_defines.svh on the include path and idb_bank as the only design under test.
`include "idb_defines.svh"

module idb_bank_bench;
    timeunit 1ns;
    timeprecision 1ns;

    localparam logic [10:0] maker_code = 11'h2A3; // Arbitrary value.
    localparam logic [11:0] part_code  = 12'h3C5; // Arbitrary value.
    localparam logic [3:0]  revision   = 4'h7;    // Arbitrary value.
    localparam logic [15:0] maker_word = {maker_code, 5'h03};
    localparam logic [15:0] part_word  = {part_code, revision};

    logic        clk_sys         = 1'b0;
    logic        rst_b           = 1'b0;
    logic [15:0] addr            = 16'h0000;
    logic        rd_stb          = 1'b0;
    logic        wr_stb          = 1'b0;
    logic [15:0] wdata           = 16'h0000;
    logic [1:0]  byte_en         = 2'h0;
    logic        ext_access_pin  = 1'b0;
    logic        flash_init_done = 1'b0;
    logic [15:0] rdata;
    logic        rd_valid;
    logic        hit;
    logic        wr_ignored;
    logic        init_ready;
    logic        strap_internal;
    int          n_mismatch      = 0;
    int          compares        = 0;
    logic [15:0] addr_tab [4]    = '{`IDB_ADDR_PROG, `IDB_ADDR_MEMORY,
                                     `IDB_ADDR_PART, `IDB_ADDR_MAKER};
    logic [15:0] busy_tab [4]    = '{`IDB_PROG_WORD, `IDB_MEM_BUSY_WORD, part_word, maker_word};
    logic [15:0] ready_tab [4]   = '{`IDB_PROG_WORD, `IDB_MEM_READY_WORD, part_word, maker_word};
    logic [15:0] hole_tab [6]    = '{16'hF076, 16'hF080, 16'hF079, 16'hF07B, 16'h0000, 16'hF17A};
    logic [1:0]  be_tab [4]      = '{2'h3, 2'h1, 2'h2, 2'h0};

    ////////////////////////////////////////////////////////////////////////////////
    // Clock at 100 ns and the bank under test, identity parameters set from this bench.
    always #50 clk_sys = ~clk_sys;

    idb_bank #(
        .MAKER_CODE (maker_code),
        .PART_CODE  (part_code),
        .REVISION   (revision)
    ) DUT (
        .CLK_SYS         (clk_sys),
        .RST_B           (rst_b),
        .ADDR            (addr),
        .RD_STB          (rd_stb),
        .WR_STB          (wr_stb),
        .WDATA           (wdata),
        .BYTE_EN         (byte_en),
        .EXT_ACCESS_PIN  (ext_access_pin),
        .FLASH_INIT_DONE (flash_init_done),
        .RDATA           (rdata),
        .RD_VALID        (rd_valid),
        .HIT             (hit),
        .WR_IGNORED      (wr_ignored),
        .INIT_READY      (init_ready),
        .STRAP_INTERNAL  (strap_internal)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Shared tasks: compare, word read, word write, reset, bounded wait for ready.
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // The strobe is one cycle wide; outputs are sampled 1 ns after the answering edge.
    task automatic read_word(input logic [15:0] a, input logic [15:0] exp, input logic exp_hit);
        @(posedge clk_sys);
        addr   <= a;
        rd_stb <= 1'b1;
        @(posedge clk_sys);
        rd_stb <= 1'b0;
        #1;
        check($sformatf("valid at %h", a), 16'h0001, {15'h0000, rd_valid});
        check($sformatf("hit at %h", a), {15'h0000, exp_hit}, {15'h0000, hit});
        check($sformatf("data at %h", a), exp, rdata);
    endtask

    task automatic write_word(input logic [15:0] a, input logic [1:0] be);
        @(posedge clk_sys);
        addr    <= a;
        wdata   <= 16'hFFFF;
        byte_en <= be;
        wr_stb  <= 1'b1;
        @(posedge clk_sys);
        wr_stb <= 1'b0;
        #1;
        check($sformatf("write ignored at %h", a), 16'h0001, {15'h0000, wr_ignored});
    endtask

    task automatic do_reset(input logic strap, input logic done);
        @(posedge clk_sys);
        ext_access_pin  <= strap;
        flash_init_done <= done;
        rst_b           <= 1'b0;
        repeat (20) @(posedge clk_sys);
        rst_b <= 1'b1;
    endtask

    // A ready flag that never comes would hang polling software, so the wait is bounded.
    task automatic wait_ready();
        for (int i = 0; i < 8; i++)
        begin
            @(posedge clk_sys);
            #1;
            if (init_ready === 1'b1)
                break;
        end
        if (init_ready !== 1'b1)
        begin
            n_mismatch++;
            $display("[ERR] init ready expected 1 seen %b", init_ready);
            finish_test();
        end
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence: external start, writes, holes, init completion, internal start.
    initial
    begin
        do_reset(1'b0, 1'b0);
        #1;
        check("init ready after reset", 16'h0000, {15'h0000, init_ready});
        check("strap external", 16'h0000, {15'h0000, strap_internal});
        for (int i = 0; i < 4; i++)
            read_word(addr_tab[i], busy_tab[i], 1'b1);
        read_word(`IDB_ADDR_MEMORY, `IDB_MEM_BUSY_WORD, 1'b1);
        check("busy bits", 16'h0003, {14'h0000, rdata[15:14]});
        for (int i = 0; i < 4; i++)
            write_word(addr_tab[i], be_tab[i]);
        for (int i = 0; i < 4; i++)
            read_word(addr_tab[i], busy_tab[i], 1'b1);
        for (int i = 0; i < 6; i++)
            read_word(hole_tab[i], 16'h0000, 1'b0);
        // Completion is polled through the busy bits, the way externally booted code must.
        // The first poll lands inside the synchroniser delay and must still see busy.
        @(posedge clk_sys);
        flash_init_done <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            read_word(`IDB_ADDR_MEMORY,
                      (i == 0) ? `IDB_MEM_BUSY_WORD : `IDB_MEM_READY_WORD, 1'b1);
            if (rdata[15:14] === 2'h0)
                break;
        end
        check("memory word ready", `IDB_MEM_READY_WORD, rdata);
        // 832 Kbyte is 340h, four times the capacity code.
        check("capacity in kbyte", 16'h0340, {2'h0, rdata[11:0], 2'h0});
        check("memory kind", {12'h000, `IDB_KIND_HP_FLASH}, {12'h000, rdata[15:12]});
        for (int i = 0; i < 4; i++)
            read_word(addr_tab[i], ready_tab[i], 1'b1);
        // A done level that falls again must not bring the busy pattern back.
        @(posedge clk_sys);
        flash_init_done <= 1'b0;
        repeat (4) @(posedge clk_sys);
        read_word(`IDB_ADDR_MEMORY, `IDB_MEM_READY_WORD, 1'b1);
        write_word(`IDB_ADDR_MEMORY, 2'h3);
        read_word(`IDB_ADDR_MEMORY, `IDB_MEM_READY_WORD, 1'b1);
        // Second reset in mid-run: internal start with the flash done level still low.
        do_reset(1'b1, 1'b0);
        wait_ready();
        check("strap internal", 16'h0001, {15'h0000, strap_internal});
        for (int i = 0; i < 4; i++)
            read_word(addr_tab[i], ready_tab[i], 1'b1);
        finish_test();
    end

    // Cuts a hang short at 20000 cycles, well above the normal run length.
    initial
    begin
        repeat (20000) @(posedge clk_sys);
        n_mismatch++;
        $display("[ERR] run length expected under 20000 cycles seen limit reached");
        finish_test();
    end
endmodule
